/* File: core/srwi_filter.sv */
// low-pulse glitch filter for the push-button input
`timescale 1ns/100ps
module srwi_filter
	import srwi_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic inN,
	output logic outLow
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] lowCnt; // consecutive low samples seen
		logic low; // filtered low level
	} srwi_filt_st_t;

	srwi_filt_st_t st_r;
	srwi_filt_st_t st_nxt;

	// count lows; any high sample restarts the count
	always_comb begin
		st_nxt = st_r;
		if (inN) begin
			st_nxt.lowCnt = 2'h0;
			st_nxt.low = 1'b0;
		end else if (st_r.lowCnt == GLITCH_LAST) begin
			st_nxt.low = 1'b1;
		end else begin
			st_nxt.lowCnt = st_r.lowCnt + 2'h1;
		end
	end

	// register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= '{lowCnt: 2'h0, low: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign outLow = st_r.low;

endmodule

/* File: core/srwi_pkg.sv */
// constants, types and register decoding shared by the supervisor block
package srwi_pkg;

	// ------------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ = 25000000; // system clock rate
	localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ; // clock period
	localparam int CYC_PER_MS = CLK_HZ / 1000; // clock cycles per ms
	localparam int RESET_TIMEOUT_INTERVAL_MS = 200; // reset stretch
	localparam int RST_CYC_DEF = RESET_TIMEOUT_INTERVAL_MS * CYC_PER_MS;
	localparam int WD_TIMEOUT_MS = 1600; // watchdog interval, 1.6 s
	localparam int WD_CYC_DEF = WD_TIMEOUT_MS * CYC_PER_MS;
	localparam int PROG_TIME_MS = 5; // internal program cycle
	localparam int PROG_CYC_DEF = PROG_TIME_MS * CYC_PER_MS;
	localparam int BUTTON_GLITCH_NS = 100; // longest button low that is ignored
	// a low just under the glitch time can still cover one more sample
	localparam int BUTTON_GLITCH_CYC = BUTTON_GLITCH_NS / CLK_PERIOD_NS + 2;
	localparam logic [1:0] GLITCH_LAST = 2'(BUTTON_GLITCH_CYC - 1);
	localparam int CNT_W = 26; // width of the long timers

	// ------------------------------------------------------------------
	// serial bus
	// ------------------------------------------------------------------
	localparam logic [3:0] DEV_TYPE = 4'hA; // device type nibble 1010
	localparam logic [3:0] BYTE_BITS = 4'h8; // bits in one byte
	localparam logic [3:0] LAST_BIT = 4'h7; // index of the last sent bit

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8; // apb address width
	localparam logic [7:0] OFF_CTRL = 8'h00; // control
	localparam logic [7:0] OFF_TXDATA = 8'h04; // byte sent on reads
	localparam logic [7:0] OFF_RXDATA = 8'h08; // last word address or accepted data byte
	localparam logic [7:0] OFF_STATUS = 8'h0C; // live status
	localparam int CTRL_WDSDA_BIT = 0; // watchdog watches the data line
	localparam logic CTRL_WDSDA_RST = 1'b0; // default: dedicated kick pin
	localparam int ST_RST_BIT = 0; // reset outputs active
	localparam int ST_BUSY_BIT = 1; // program cycle running
	localparam int ST_SEL_BIT = 2; // serial transaction in progress
	localparam int ST_WP_BIT = 3; // write protect pin level
	localparam int ST_W = 4; // status width

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_WRX, I2C_RTX, I2C_RACK, I2C_WAIT
	} srwi_i2c_t;

	typedef enum logic [2:0] {
		REG_CTRL, REG_TX, REG_RX, REG_ST, REG_NONE
	} srwi_reg_t;

	// pin inputs that cross into the clock domain together
	typedef struct packed {
		logic scl;
		logic sda;
		logic rstIoN;
		logic buttonN;
		logic kick;
		logic wp;
	} srwi_pins_t;

	localparam srwi_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1,
		rstIoN: 1'b1, buttonN: 1'b1, kick: 1'b0, wp: 1'b0};

	// map an apb address onto a register
	function automatic srwi_reg_t srwiDecode(input logic [ADDR_W-1:0] a);
		case (a)
			OFF_CTRL: return REG_CTRL;
			OFF_TXDATA: return REG_TX;
			OFF_RXDATA: return REG_RX;
			OFF_STATUS: return REG_ST;
			default: return REG_NONE;
		endcase
	endfunction

endpackage

/* File: core/srwi_sync.sv */
// two-flop synchroniser for the pin inputs
`timescale 1ns/100ps
module srwi_sync
	import srwi_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire srwi_pins_t pinsIn,
	output srwi_pins_t pinsOut
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		srwi_pins_t s1; // first stage, read only by the second
		srwi_pins_t s2; // second stage, safe to use
	} srwi_sync_st_t;

	srwi_sync_st_t st_r;
	srwi_sync_st_t st_nxt;

	// shift the samples along
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pinsIn;
		st_nxt.s2 = st_r.s1;
	end

	// register, idle pin levels under reset
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= '{s1: PINS_IDLE, s2: PINS_IDLE};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pinsOut = st_r.s2;

endmodule

/* File: core/srwi_top.sv */
// supervisor: reset generator, watchdog and serial slave front end
//
// Contract
// - power-up: hold reset, then 200 ms more
// - supply below threshold asserts reset at once
// - falling reset pin starts a full timeout
// - short external reset still gives 200 ms
// - button low holds reset, plus one timeout
// - button lows under 100 ns are ignored
// - reset aborts serial transaction, blocks memory
// - no program start in reset; running finishes
// - write protect high blocks memory writes
// - no line toggle for 1.6 s: reset
// - watchdog watches kick pin or data line
// - any monitored edge clears watchdog counter
// - watchdog held cleared while reset active
// - data moves only while clock low
// - START is data fall, clock high
// - STOP is data rise, clock high; ends transaction
// - match upper address nibble against 1010
// - address bit zero selects read or write
// - receiver pulls data low on ninth clock
// - ack own address and written bytes
// - read: send byte, sample ack, else wait
// - no address ack during program cycle
`timescale 1ns/100ps
module srwi_top
	import srwi_pkg::*;
#(
	parameter int unsigned RST_CYC = RST_CYC_DEF, // reset stretch cycles
	parameter int unsigned WD_CYC = WD_CYC_DEF, // watchdog cycles
	parameter int unsigned PROG_CYC = PROG_CYC_DEF // program cycles
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic belowSupplyThreshold,
	input wire logic pushbuttonResetN,
	input wire logic watchdogKickIn,
	input wire logic writeProtect,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic resetIoInN,
	output logic resetIoOutN,
	output logic resetIoOe,
	output logic resetOut,
	output logic memAccessEn,
	output logic progBusy
);

	// ------------------------------------------------------------------
	// constants at counter width
	// ------------------------------------------------------------------
	localparam logic [CNT_W-1:0] RST_LOAD = CNT_W'(RST_CYC);
	localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WD_CYC - 1);
	localparam logic [CNT_W-1:0] PROG_LOAD = CNT_W'(PROG_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE = 26'h0000001;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [CNT_W-1:0] rstCnt; // reset stretch countdown
		logic rstAct; // reset outputs active
		logic memEn; // memory operations allowed
		logic [CNT_W-1:0] wdCnt; // watchdog idle time
		logic monD; // monitored line, last sample
		logic [CNT_W-1:0] progCnt; // program cycle countdown
		logic progBusy; // program cycle running
		logic sclD; // clock line, last sample
		logic sdaD; // data line, last sample
		logic rstIoD; // reset pin, last sample
		srwi_i2c_t i2c; // serial front end state
		logic [3:0] bitCnt; // bits moved in this byte
		logic [7:0] rxSh; // receive shifter
		logic [7:0] txSh; // transmit shifter
		logic rdMode; // direction taken from the address
		logic wordSeen; // word address byte received
		logic dataSeen; // data byte accepted for writing
		logic masterAck; // master acked the last sent byte
		logic sdaLow; // pull the data line low
		logic wdUseSda; // watchdog watches the data line
		logic [7:0] txData; // byte served on reads
		logic [7:0] rxData; // last word address or accepted data byte
		logic [31:0] prdata; // apb read data
		logic pslverr; // apb error answer
	} srwi_top_st_t;

	localparam srwi_top_st_t ST_RST = '{rstCnt: RST_LOAD, rstAct: 1'b1,
		sclD: 1'b1, sdaD: 1'b1, rstIoD: 1'b1, i2c: I2C_IDLE,
		wdUseSda: CTRL_WDSDA_RST, default: '0};

	srwi_top_st_t st_r;
	srwi_top_st_t st_nxt;

	srwi_pins_t pinsRaw; // pins before synchronising
	srwi_pins_t pinsS; // pins after two flops
	logic buttonLow; // filtered push-button level
	logic sclRise, sclFall, startEv, stopEv, byteDone;
	logic ioFall, monS, monEdge, wdTrip, hold, progStart, addrMatch;
	logic rdAcc, wrAcc;
	srwi_reg_t regSel; // register picked by paddr
	logic [ST_W-1:0] statusVec; // live status bits

	// ------------------------------------------------------------------
	// input conditioning
	// ------------------------------------------------------------------
	assign pinsRaw = '{scl: scl, sda: sdaIn, rstIoN: resetIoInN,
		buttonN: pushbuttonResetN, kick: watchdogKickIn, wp: writeProtect};

	srwi_sync uSync (
		.clk(clk),
		.rst_b(rst_b),
		.pinsIn(pinsRaw),
		.pinsOut(pinsS)
	);

	// short button lows never reach the reset logic
	srwi_filter uFilter (
		.clk(clk),
		.rst_b(rst_b),
		.inN(pinsS.buttonN),
		.outLow(buttonLow)
	);

	// ------------------------------------------------------------------
	// events
	// ------------------------------------------------------------------
	assign sclRise = pinsS.scl & ~st_r.sclD;
	assign sclFall = ~pinsS.scl & st_r.sclD;
	// data edges while the clock stays high are bus conditions
	assign startEv = pinsS.scl & st_r.sclD & st_r.sdaD & ~pinsS.sda;
	assign stopEv = pinsS.scl & st_r.sclD & ~st_r.sdaD & pinsS.sda;
	assign byteDone = sclFall & (st_r.bitCnt == BYTE_BITS);
	// own drive of the pin must not retrigger, so only outside reset
	assign ioFall = st_r.rstIoD & ~pinsS.rstIoN & ~st_r.rstAct;
	assign monS = st_r.wdUseSda ? pinsS.sda : pinsS.kick;
	assign monEdge = monS ^ st_r.monD;
	assign wdTrip = (st_r.wdCnt == WD_LAST) & ~st_r.rstAct & ~monEdge;
	// comparator level is already clean and on this clock
	assign hold = belowSupplyThreshold | buttonLow;
	assign addrMatch = (st_r.rxSh[7:4] == DEV_TYPE) & ~st_r.progBusy;
	assign progStart = stopEv & ~st_r.rstAct & st_r.dataSeen & ~st_r.rdMode
		& ~pinsS.wp & ~st_r.progBusy;

	// apb phases: read data prepared in setup, writes land in access
	assign regSel = srwiDecode(paddr);
	assign rdAcc = psel & ~penable;
	assign wrAcc = psel & penable & pwrite;
	assign statusVec = {pinsS.wp, st_r.i2c != I2C_IDLE, st_r.progBusy,
		st_r.rstAct};

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.sclD = pinsS.scl;
		st_nxt.sdaD = pinsS.sda;
		st_nxt.rstIoD = pinsS.rstIoN;
		st_nxt.monD = monS;

		// reset stretch: any cause reloads the full interval
		if (hold | ioFall | wdTrip) begin
			st_nxt.rstCnt = RST_LOAD;
		end else if (st_r.rstCnt != '0) begin
			st_nxt.rstCnt = st_r.rstCnt - CNT_ONE;
		end
		st_nxt.rstAct = (st_nxt.rstCnt != '0);
		st_nxt.memEn = ~st_nxt.rstAct;

		// watchdog: cleared by edges, by reset and on expiry, else counts
		if (st_r.rstAct | monEdge | wdTrip) begin
			st_nxt.wdCnt = '0;
		end else begin
			st_nxt.wdCnt = st_r.wdCnt + CNT_ONE;
		end

		// program cycle: started by stop, never cut short by reset
		if (progStart) begin
			st_nxt.progCnt = PROG_LOAD;
		end else if (st_r.progCnt != '0) begin
			st_nxt.progCnt = st_r.progCnt - CNT_ONE;
		end
		st_nxt.progBusy = (st_nxt.progCnt != '0);

		// serial front end
		if (st_r.rstAct) begin
			// abort and refuse everything
			st_nxt.i2c = I2C_IDLE;
			st_nxt.sdaLow = 1'b0;
			st_nxt.dataSeen = 1'b0;
		end else if (startEv) begin
			// start or repeated start: take an address
			st_nxt.i2c = I2C_ADDR;
			st_nxt.bitCnt = '0;
			st_nxt.sdaLow = 1'b0;
			st_nxt.wordSeen = 1'b0;
			st_nxt.dataSeen = 1'b0;
		end else if (stopEv) begin
			// end of transaction from any state
			st_nxt.i2c = I2C_IDLE;
			st_nxt.sdaLow = 1'b0;
			st_nxt.dataSeen = 1'b0;
		end else begin
			case (st_r.i2c)
				I2C_ADDR, I2C_WRX: begin
					if (sclRise) begin
						// sample on the rising clock
						st_nxt.rxSh = {st_r.rxSh[6:0], pinsS.sda};
						st_nxt.bitCnt = st_r.bitCnt + 4'h1;
					end else if (byteDone) begin
						st_nxt.i2c = I2C_WAIT;
						if (st_r.i2c == I2C_ADDR) begin
							st_nxt.rdMode = st_r.rxSh[0];
							if (addrMatch) begin
								st_nxt.sdaLow = 1'b1;
								st_nxt.i2c = I2C_ACK;
							end
						end else if (!st_r.wordSeen) begin
							// word address byte is always taken
							st_nxt.wordSeen = 1'b1;
							st_nxt.rxData = st_r.rxSh;
							st_nxt.sdaLow = 1'b1;
							st_nxt.i2c = I2C_ACK;
						end else if (!pinsS.wp) begin
							// data byte accepted for programming
							st_nxt.dataSeen = 1'b1;
							st_nxt.rxData = st_r.rxSh;
							st_nxt.sdaLow = 1'b1;
							st_nxt.i2c = I2C_ACK;
						end
						// protected data byte falls through unacked
					end
				end
				I2C_ACK: begin
					// ack held through the ninth clock
					if (sclFall) begin
						st_nxt.bitCnt = '0;
						if (st_r.rdMode) begin
							st_nxt.txSh = st_r.txData;
							st_nxt.sdaLow = ~st_r.txData[7];
							st_nxt.i2c = I2C_RTX;
						end else begin
							st_nxt.sdaLow = 1'b0;
							st_nxt.i2c = I2C_WRX;
						end
					end
				end
				I2C_RTX: begin
					// next bit goes out after each falling clock
					if (sclFall) begin
						if (st_r.bitCnt == LAST_BIT) begin
							st_nxt.sdaLow = 1'b0;
							st_nxt.i2c = I2C_RACK;
						end else begin
							st_nxt.bitCnt = st_r.bitCnt + 4'h1;
							st_nxt.txSh = {st_r.txSh[6:0], 1'b0};
							st_nxt.sdaLow = ~st_r.txSh[6];
						end
					end
				end
				I2C_RACK: begin
					// master answers on the ninth clock
					if (sclRise) begin
						st_nxt.masterAck = ~pinsS.sda;
					end else if (sclFall) begin
						if (st_r.masterAck) begin
							st_nxt.bitCnt = '0;
							st_nxt.txSh = st_r.txData;
							st_nxt.sdaLow = ~st_r.txData[7];
							st_nxt.i2c = I2C_RTX;
						end else begin
							st_nxt.i2c = I2C_WAIT;
						end
					end
				end
				I2C_IDLE, I2C_WAIT: begin
					// wait for a bus condition
					st_nxt.sdaLow = 1'b0;
				end
				default: begin
					st_nxt.i2c = I2C_IDLE;
				end
			endcase
		end

		// apb read data and error, captured in the setup phase
		if (rdAcc) begin
			st_nxt.prdata = '0;
			st_nxt.pslverr = (regSel == REG_NONE);
			case (regSel)
				REG_CTRL: st_nxt.prdata[CTRL_WDSDA_BIT] = st_r.wdUseSda;
				REG_TX: st_nxt.prdata[7:0] = st_r.txData;
				REG_RX: st_nxt.prdata[7:0] = st_r.rxData;
				REG_ST: st_nxt.prdata[ST_W-1:0] = statusVec;
				default: st_nxt.prdata = '0;
			endcase
		end

		// apb writes, taken at the access edge
		if (wrAcc) begin
			case (regSel)
				REG_CTRL: st_nxt.wdUseSda = pwdata[CTRL_WDSDA_BIT];
				REG_TX: st_nxt.txData = pwdata[7:0];
				default: st_nxt.txData = st_r.txData;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign prdata = st_r.prdata;
	assign pready = 1'b1;
	assign pslverr = st_r.pslverr;
	assign sdaOut = 1'b0;
	assign sdaOe = st_r.sdaLow;
	assign resetIoOutN = 1'b0;
	assign resetIoOe = st_r.rstAct;
	assign resetOut = st_r.rstAct;
	assign memAccessEn = st_r.memEn;
	assign progBusy = st_r.progBusy;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	supply_drop_a: assert property (
		belowSupplyThreshold |=> resetOut && st_r.rstCnt == RST_LOAD)
		else $error("supply drop did not assert reset");

	powerup_stretch_a: assert property (
		!hold && $past(hold) |-> st_r.rstCnt == RST_LOAD ##1 resetOut [*8])
		else $error("reset not stretched after threshold");

	pin_edge_a: assert property (
		ioFall |=> st_r.rstCnt == RST_LOAD ##1 resetOut [*8])
		else $error("reset pin edge did not start timeout");

	full_timeout_a: assert property (
		$fell(resetOut) |-> $past(st_r.rstCnt) == CNT_ONE && !$past(hold))
		else $error("reset released before timeout ran out");

	button_hold_a: assert property (
		buttonLow |=> resetOut && st_r.rstCnt == RST_LOAD)
		else $error("button low did not hold reset");

	glitch_reject_a: assert property (
		buttonLow |-> !$past(pinsS.buttonN, 1) && !$past(pinsS.buttonN, 2)
			&& !$past(pinsS.buttonN, 3) && !$past(pinsS.buttonN, 4))
		else $error("short button low reached reset");

	reset_abort_a: assert property (
		st_r.rstAct |=> st_r.i2c == I2C_IDLE && !sdaOe)
		else $error("serial front end active during reset");

	prog_block_a: assert property (
		st_r.rstAct && !st_r.progBusy |=> !progBusy)
		else $error("program cycle started in reset");

	wp_block_a: assert property (
		pinsS.wp && !st_r.progBusy |=> !progBusy)
		else $error("program cycle started while protected");

	wd_expire_a: assert property (
		wdTrip |=> resetOut && st_r.rstCnt == RST_LOAD && st_r.wdCnt == '0)
		else $error("watchdog expiry gave no reset");

	wd_clear_a: assert property (
		monEdge |=> st_r.wdCnt == '0)
		else $error("monitored edge did not clear watchdog");

	wd_frozen_a: assert property (
		st_r.rstAct |=> st_r.wdCnt == '0)
		else $error("watchdog counted during reset");

	idle_ignore_a: assert property (
		st_r.i2c == I2C_IDLE && !startEv |=> st_r.i2c == I2C_IDLE && !sdaOe)
		else $error("bus activity taken without start");

	busy_nack_a: assert property (
		st_r.i2c == I2C_ADDR && byteDone && st_r.progBusy && !st_r.rstAct
			|=> st_r.i2c == I2C_WAIT && !sdaOe)
		else $error("address acked during program cycle");

	read_nack_a: assert property (
		st_r.i2c == I2C_RACK && sclFall && !st_r.masterAck && !st_r.rstAct
			&& !startEv && !stopEv |=> st_r.i2c == I2C_WAIT && !sdaOe)
		else $error("sending went on without master ack");

endmodule

/* File: dv/srwi_host_model.sv */
// host bus master model: drives the serial clock and pulls data low
`timescale 1ns/100ps
module srwi_host_model (
	input wire logic clk,
	input wire logic sdaLine,
	output logic scl,
	output logic pullLow
);
	// idle bus: clock high, data released to its pull-up
	initial begin
		scl = 1'h1;
		pullLow = 1'h0;
	end
	// one bit: data moves while clock low, sampled late in the high phase
	task automatic bitIo(input logic b, output logic r);
		pullLow <= !b;
		repeat (3) @(posedge clk);
		scl <= 1'h1;
		repeat (4) @(posedge clk);
		r = sdaLine;
		scl <= 1'h0;
		@(posedge clk);
	endtask
	// start only from an idle bus: data falls while clock high
	task automatic start();
		pullLow <= 1'h1;
		repeat (4) @(posedge clk);
		scl <= 1'h0;
		@(posedge clk);
	endtask
	// stop: data rises while clock high, then the bus idles
	task automatic stop();
		pullLow <= 1'h1;
		repeat (3) @(posedge clk);
		scl <= 1'h1;
		repeat (4) @(posedge clk);
		pullLow <= 1'h0;
		repeat (4) @(posedge clk);
	endtask
	// eight bits msb first, ninth clock samples the acknowledge
	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitIo(d[i], r);
		bitIo(1'h1, r);
		ack = !r;
	endtask
	// take eight bits, then acknowledge or leave the line released
	task automatic readByte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitIo(1'h1, d[i]);
		bitIo(!ack, r);
	endtask
endmodule

/* File: dv/tb_srwi_top.sv */
// self-checking bench for the supervisor block
`timescale 1ns/100ps
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin failCount++; \
	$display("unexpected at %0t: got %0h want %0h", $time, a, e); end end
module tb_srwi_top
	import srwi_pkg::*;
;
	localparam int RC = 64; // shortened reset stretch
	localparam int WC = 400; // shortened watchdog interval
	localparam int PC = 100; // shortened program cycle
	logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, sdaOut, sdaOe, resetIoOutN, resetIoOe, resetOut;
	logic memAccessEn, progBusy, scl, pullLow, err, ack;
	logic supply = 1'h0, buttonN = 1'h1, kick = 1'h0, wp = 1'h0;
	logic extLow = 1'h0, kickOn = 1'h1;
	logic [6:0] kickCnt = 7'h00; // paces the watchdog kicks
	logic [7:0] b;
	int failCount = 0, checkCount = 0, c;
	// wired levels of the open-drain data line and the reset pin
	wire logic sdaLine = !(pullLow | (sdaOe & !sdaOut));
	wire logic rstPinN = !(extLow | (resetIoOe & !resetIoOutN));
	always #20 clk = !clk;
	srwi_top #(.RST_CYC(RC), .WD_CYC(WC), .PROG_CYC(PC)) dut (.clk(clk),
		.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .belowSupplyThreshold(supply),
		.pushbuttonResetN(buttonN), .watchdogKickIn(kick), .writeProtect(wp),
		.scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.resetIoInN(rstPinN), .resetIoOutN(resetIoOutN),
		.resetIoOe(resetIoOe), .resetOut(resetOut),
		.memAccessEn(memAccessEn), .progBusy(progBusy));
	srwi_host_model host (.clk(clk), .sdaLine(sdaLine), .scl(scl),
		.pullLow(pullLow));
	// kick pin toggles every 64 cycles while kicking is on
	always @(posedge clk) begin
		kickCnt <= kickCnt + 7'h01;
		if (kickOn) kick <= kickCnt[6];
	end
	// one apb transfer; result left in rd and err
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		// no wait limit here: only the hang guard ends a stuck access
		while (pready !== 1'h1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	// cycles until resetOut shows v, at most lim
	task automatic waitRst(input logic v, input int lim, output int n);
		n = 0;
		while (resetOut !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic endOfTest();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (30000) @(posedge clk);
		failCount++;
		endOfTest();
	end
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		`CHK(resetOut, 1'h1)
		waitRst(1'h0, RC + 20, c);
		`CHK(c >= RC && c <= RC + 3, 1'h1)
		`CHK(memAccessEn, 1'h1)
		apb(1'h1, OFF_TXDATA, 32'h5A);
		apb(1'h0, OFF_TXDATA, 32'h0);
		`CHK(rd, 32'h5A)
		apb(1'h0, 8'h10, 32'h0);
		`CHK(({err, rd}), 33'h100000000)
		apb(1'h1, OFF_STATUS, 32'hF);
		apb(1'h0, OFF_STATUS, 32'h0);
		`CHK(rd, 32'h0)
		// byte write, then addressing while programming
		host.start();
		host.sendByte(8'hA0, ack);
		`CHK(ack, 1'h1)
		host.sendByte(8'h12, ack);
		`CHK(ack, 1'h1)
		host.sendByte(8'h34, ack);
		`CHK(ack, 1'h1)
		host.stop();
		host.start();
		host.sendByte(8'hA0, ack);
		`CHK(({progBusy, ack}), 2'h2)
		host.stop();
		// a reset in the middle of the program cycle must not cut it short
		supply <= 1'h1;
		repeat (2) @(posedge clk);
		`CHK(({resetOut, progBusy}), 2'h3)
		supply <= 1'h0;
		waitRst(1'h0, RC + 20, c);
		apb(1'h0, OFF_RXDATA, 32'h0);
		`CHK(rd, 32'h34)
		repeat (PC) @(posedge clk);
		`CHK(progBusy, 1'h0)
		// foreign device type
		host.start();
		host.sendByte(8'hB0, ack);
		`CHK(ack, 1'h0)
		host.stop();
		// read two bytes, second one not acknowledged
		host.start();
		host.sendByte(8'hA1, ack);
		`CHK(ack, 1'h1)
		host.readByte(1'h1, b);
		`CHK(b, 8'h5A)
		host.readByte(1'h0, b);
		`CHK(b, 8'h5A)
		host.stop();
		// write protect refuses the data byte
		wp <= 1'h1;
		host.start();
		host.sendByte(8'hA0, ack);
		host.sendByte(8'h12, ack);
		`CHK(ack, 1'h1)
		host.sendByte(8'h77, ack);
		`CHK(ack, 1'h0)
		host.stop();
		repeat (8) @(posedge clk);
		`CHK(progBusy, 1'h0)
		wp <= 1'h0;
		// supply drop aborts a write whose data byte was already taken
		host.start();
		host.sendByte(8'hA0, ack);
		host.sendByte(8'h12, ack);
		host.sendByte(8'h56, ack);
		supply <= 1'h1;
		repeat (2) @(posedge clk);
		`CHK(({resetOut, resetIoOe, memAccessEn}), 3'h6)
		apb(1'h0, OFF_STATUS, 32'h0);
		`CHK(rd, 32'h1)
		host.sendByte(8'h78, ack);
		`CHK(ack, 1'h0)
		host.stop();
		supply <= 1'h0;
		waitRst(1'h0, RC + 20, c);
		`CHK(c >= RC && c <= RC + 3, 1'h1)
		`CHK(progBusy, 1'h0)
		// button glitch, then a held press
		buttonN <= 1'h0;
		repeat (2) @(posedge clk);
		buttonN <= 1'h1;
		waitRst(1'h1, 20, c);
		`CHK(c, 20)
		buttonN <= 1'h0;
		repeat (30) @(posedge clk);
		`CHK(resetOut, 1'h1)
		buttonN <= 1'h1;
		waitRst(1'h0, RC + 20, c);
		`CHK(c >= RC && c <= RC + 10, 1'h1)
		// short pulse on the reset pin
		extLow <= 1'h1;
		repeat (3) @(posedge clk);
		extLow <= 1'h0;
		waitRst(1'h1, 10, c);
		`CHK(c < 10, 1'h1)
		waitRst(1'h0, RC + 20, c);
		`CHK(c >= RC - 1 && c <= RC + 3, 1'h1)
		// watchdog: starve, keep alive, then watch the data line
		kickOn <= 1'h0;
		waitRst(1'h1, WC + 20, c);
		`CHK(c >= WC - 70 && c <= WC + 10, 1'h1)
		kickOn <= 1'h1;
		waitRst(1'h0, RC + 20, c);
		waitRst(1'h1, 2 * WC, c);
		`CHK(c, 2 * WC)
		apb(1'h1, OFF_CTRL, 32'h1);
		waitRst(1'h1, WC + 20, c);
		`CHK(c >= WC - 140 && c <= WC + 10, 1'h1)
		apb(1'h1, OFF_CTRL, 32'h0);
		waitRst(1'h0, RC + 20, c);
		endOfTest();
	end
endmodule
